// ==== pkg/spsf_pkg.sv ====
// constants, field layout and helpers for the port status field bank
package spsf_pkg;

    // speed codes shared by the limit and capability fields
    localparam logic [2:0] SPD_S100 = 3'h0;
    localparam logic [2:0] SPD_S200 = 3'h1;
    localparam logic [2:0] SPD_S400 = 3'h2;
    localparam logic [2:0] SPD_S800 = 3'h3;
    localparam logic [2:0] SPD_S1600 = 3'h4;
    localparam logic [2:0] SPD_S3200 = 3'h5;
    localparam logic [2:0] SPD_RSVD6 = 3'h6;
    localparam logic [2:0] SPD_RSVD7 = 3'h7;
    // a bilingual port trains its b speed at this fixed code
    localparam logic [2:0] SPD_BILINGUAL = SPD_S400;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PSEL_W = 2;
    localparam int NPORTS_DEF = 3;

    // register offsets
    localparam logic [3:0] ADDR_SPEED = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_ERRCNT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;

    // speed register fields
    localparam int SPD_LIMIT_LSB = 0;
    localparam int SPD_CAP_LSB = 4;
    localparam int SPD_PLUG_BIT = 7;
    localparam logic LOCAL_PLUG_VAL = 1'b1;

    // status register fields
    localparam int ST_UNREL_BIT = 0;
    localparam int ST_BSIG_BIT = 1;
    localparam int ST_CON_BIT = 2;
    localparam int ST_RECEIVE_GOOD_BIT = 3;
    localparam int ST_SLEEP_BIT = 4;
    localparam int ST_SLPEN_BIT = 5;

    // interrupt status / mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_UNREL_BIT = 0;
    localparam int IRQ_CODE_BIT = 1;
    localparam int IRQ_CON_BIT = 2;
    localparam int IRQ_SLEEP_BIT = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // invalid code counter
    localparam logic [7:0] ERRCNT_RST = 8'h00;
    localparam logic [7:0] ERRCNT_MAX = 8'hff;

    // connection debounce timing
    localparam int CLK_KHZ = 10_000;
    localparam int DEBOUNCE_MS = 341;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int DEB_W = 22;

    // a requested speed above the port's capability is cut back to it
    function automatic logic [2:0] spsf_clamp_speed(input logic [2:0] req,
                                                    input logic [2:0] cap);
        return (req > cap) ? cap : req;
    endfunction

endpackage

// ==== hdl/spsf_debounce.sv ====
// connection debouncer: output rises only after the raw level stays high
`timescale 1ns/100ps
module spsf_debounce #(
    parameter int CYCLES = spsf_pkg::DEBOUNCE_CYC,
    parameter int W = spsf_pkg::DEB_W
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic raw,
    output logic stable
);
    import spsf_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic stable;
    } spsf_deb_state_t;

    spsf_deb_state_t s_reg;
    spsf_deb_state_t s_next;

    // terminal count; a zero setting still waits one cycle
    localparam logic [W-1:0] LAST = (CYCLES > 1) ? W'(CYCLES - 1) : '0;

    // a drop clears at once, only the rise is filtered against contact bounce
    always_comb begin
        s_next = s_reg;
        if (!raw) begin
            s_next.cnt = '0;
            s_next.stable = 1'b0;
        end else if (s_reg.cnt != LAST) begin
            s_next.cnt = s_reg.cnt + W'(1);
        end else begin
            s_next.stable = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign stable = s_reg.stable;

    a_debounce_rise: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $rose(s_reg.stable) |-> (s_reg.cnt == LAST) && $past(raw))
        else $error("connection rose before debounce interval");

endmodule

// ==== hdl/spsf_port_status.sv ====
// per-port status field bank: speed limit, link flags, error counter, sleep
//
// Operation
// - speed codes S100..S3200 are 000..101, 110/111 reserved
// - written limit above capability stores capability
// - limit used only at new b-only connection
// - bilingual port limit fixed at 010, writes ignored
// - b-only limit resets to port's highest capable speed, bilingual to 010
// - local plug flag always reads one
// - capability field reports port's highest b speed
// - negotiation or sync failure sets unreliable flag
// - writing one clears the unreliable flag
// - b indicator high only while b signaling active
// - connected, receive good, not b means legacy
// - invalid code counter counts, saturates at 255
// - a counter read clears it to zero, or to one with a same-cycle code
// - sleep flag mirrors the port's sleep state
// - sleep entered only when sleep is enabled
// - sleep enables loaded from strap, then writable
// - connection set after 341 ms stable
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module spsf_port_status #(
    parameter int NPORTS = spsf_pkg::NPORTS_DEF,
    parameter logic [NPORTS-1:0][2:0] PORT_CAP = {NPORTS{spsf_pkg::SPD_S400}},
    parameter logic [NPORTS-1:0] B_ONLY = '0,
    parameter int DEBOUNCE_CYCLES = spsf_pkg::DEBOUNCE_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [spsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [spsf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spsf_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [spsf_pkg::PSEL_W-1:0] port_sel,
    input wire logic slpen_pin,
    input wire logic [NPORTS-1:0] phy_connect_raw,
    input wire logic [NPORTS-1:0] receive_good_in,
    input wire logic [NPORTS-1:0] b_link_up,
    input wire logic [NPORTS-1:0] new_b_conn,
    input wire logic [NPORTS-1:0] neg_fail,
    input wire logic [NPORTS-1:0] sync_fail,
    input wire logic [NPORTS-1:0] invalid_code,
    input wire logic [NPORTS-1:0] sleep_req,
    input wire logic [NPORTS-1:0] wake_req,
    output logic [NPORTS-1:0] port_connected,
    output logic [NPORTS-1:0] port_receive_good,
    output logic [NPORTS-1:0] port_b_signaling,
    output logic [NPORTS-1:0] port_asleep,
    output logic [NPORTS-1:0][2:0] train_speed,
    output logic irq
);
    import spsf_pkg::*;

    typedef enum logic {
        SPSF_AWAKE = 1'b0,
        SPSF_ASLEEP = 1'b1
    } spsf_sleep_t;

    typedef struct packed {
        logic [NPORTS-1:0][2:0] limit;
        logic [NPORTS-1:0][2:0] train;
        logic [NPORTS-1:0] unrel;
        logic [NPORTS-1:0][7:0] errcnt;
        logic [NPORTS-1:0] slpen;
        spsf_sleep_t [NPORTS-1:0] sleep;
        logic [NPORTS-1:0] bsig;
        logic [NPORTS-1:0] receive_good;
        logic [NPORTS-1:0] con_q;
        logic strap_done;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } spsf_state_t;

    // reset image: limit starts at each port's capability, bilingual at 010
    function automatic logic [NPORTS-1:0][2:0] reset_limits();
        logic [NPORTS-1:0][2:0] v;
        v = '0;
        for (int p = 0; p < NPORTS; p++) begin
            v[p] = B_ONLY[p] ? PORT_CAP[p] : SPD_BILINGUAL;
        end
        return v;
    endfunction

    localparam logic [NPORTS-1:0][2:0] LIMIT_RST = reset_limits();

    spsf_state_t s_reg;
    spsf_state_t s_next;
    logic [NPORTS-1:0] con_db;

    // one debouncer per port turns the raw detect into the connection bit
    for (genvar g = 0; g < NPORTS; g++) begin : g_deb
        spsf_debounce #(
            .CYCLES(DEBOUNCE_CYCLES),
            .W(DEB_W)
        ) u_deb (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .raw(phy_connect_raw[g]),
            .stable(con_db[g])
        );
    end

    // next state for all ports; the selected port alone sees bus accesses
    always_comb begin
        logic hit;
        logic [7:0] cnt;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] w1c;
        hit = 1'b0;
        cnt = '0;
        ev = '0;
        w1c = '0;
        s_next = s_reg;
        s_next.rdata = '0;

        // strap is caught by a clocked step right after reset release
        if (!s_reg.strap_done) begin
            s_next.slpen = {NPORTS{slpen_pin}};
            s_next.strap_done = 1'b1;
        end

        for (int p = 0; p < NPORTS; p++) begin
            hit = (port_sel == PSEL_W'(p));

            // speed limit: clamp b-only writes, pin bilingual ports at s400
            if (!B_ONLY[p]) begin
                s_next.limit[p] = SPD_BILINGUAL;
            end else if (reg_wr && hit && reg_addr == ADDR_SPEED) begin
                s_next.limit[p] = spsf_clamp_speed(reg_wdata[SPD_LIMIT_LSB +: 3],
                                                   PORT_CAP[p]);
            end

            // the limit is only looked at when a new b connection trains
            if (new_b_conn[p]) begin
                s_next.train[p] = B_ONLY[p] ? s_reg.limit[p] : SPD_BILINGUAL;
            end

            // unreliable flag: write one clears, a failure in the same cycle wins
            if (reg_wr && hit && reg_addr == ADDR_STATUS && reg_wdata[ST_UNREL_BIT]) begin
                s_next.unrel[p] = 1'b0;
            end
            if (neg_fail[p] || sync_fail[p]) begin
                s_next.unrel[p] = 1'b1;
                ev[IRQ_UNREL_BIT] = 1'b1;
            end

            // error counter: read clears first so a same-cycle code counts as one
            cnt = s_reg.errcnt[p];
            if (reg_rd && hit && reg_addr == ADDR_ERRCNT) begin
                cnt = ERRCNT_RST;
            end
            if (invalid_code[p]) begin
                ev[IRQ_CODE_BIT] = 1'b1;
                if (cnt != ERRCNT_MAX) begin
                    cnt = cnt + 8'h01;
                end
            end
            s_next.errcnt[p] = cnt;

            // sleep enable is per port writable once the strap is taken
            if (s_reg.strap_done && reg_wr && hit && reg_addr == ADDR_STATUS) begin
                s_next.slpen[p] = reg_wdata[ST_SLPEN_BIT];
            end

            // sleep state; entry needs the port's enable
            unique case (s_reg.sleep[p])
                SPSF_AWAKE: begin
                    if (sleep_req[p] && s_reg.slpen[p]) begin
                        s_next.sleep[p] = SPSF_ASLEEP;
                        ev[IRQ_SLEEP_BIT] = 1'b1;
                    end
                end
                SPSF_ASLEEP: begin
                    if (wake_req[p]) begin
                        s_next.sleep[p] = SPSF_AWAKE;
                    end
                end
            endcase

            // link indications are gated by the debounced connection
            s_next.bsig[p] = con_db[p] && b_link_up[p];
            s_next.receive_good[p] = con_db[p] && receive_good_in[p];
            s_next.con_q[p] = con_db[p];
            if (con_db[p] != s_reg.con_q[p]) begin
                ev[IRQ_CON_BIT] = 1'b1;
            end

            // read data of the selected port, registered for the next cycle
            if (reg_rd && hit) begin
                unique case (reg_addr)
                    ADDR_SPEED: begin
                        s_next.rdata[SPD_LIMIT_LSB +: 3] = s_reg.limit[p];
                        s_next.rdata[SPD_CAP_LSB +: 3] = PORT_CAP[p];
                        s_next.rdata[SPD_PLUG_BIT] = LOCAL_PLUG_VAL;
                    end
                    ADDR_STATUS: begin
                        s_next.rdata[ST_UNREL_BIT] = s_reg.unrel[p];
                        s_next.rdata[ST_BSIG_BIT] = s_reg.bsig[p];
                        s_next.rdata[ST_CON_BIT] = s_reg.con_q[p];
                        s_next.rdata[ST_RECEIVE_GOOD_BIT] = s_reg.receive_good[p];
                        s_next.rdata[ST_SLEEP_BIT] = (s_reg.sleep[p] == SPSF_ASLEEP);
                        s_next.rdata[ST_SLPEN_BIT] = s_reg.slpen[p];
                    end
                    ADDR_ERRCNT: begin
                        s_next.rdata = s_reg.errcnt[p];
                    end
                    default: begin
                        s_next.rdata = '0;
                    end
                endcase
            end
        end

        // interrupt registers are global, not per port
        if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
            w1c = reg_wdata[IRQ_W-1:0];
        end
        if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
            s_next.irq_mask = reg_wdata[IRQ_W-1:0];
        end
        s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
        if (reg_rd && reg_addr == ADDR_IRQ_STAT) begin
            s_next.rdata = {{(DATA_W - IRQ_W){1'b0}}, s_reg.irq_stat};
        end
        if (reg_rd && reg_addr == ADDR_IRQ_MASK) begin
            s_next.rdata = {{(DATA_W - IRQ_W){1'b0}}, s_reg.irq_mask};
        end
    end

    // state register; all reset values are constants
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0; // zero is also the awake sleep code
            s_reg.limit <= LIMIT_RST;
            s_reg.train <= LIMIT_RST;
            s_reg.irq_mask <= IRQ_MASK_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from a flop
    assign reg_rdata = s_reg.rdata;
    assign port_connected = s_reg.con_q;
    assign port_receive_good = s_reg.receive_good;
    assign port_b_signaling = s_reg.bsig;
    assign train_speed = s_reg.train;
    assign irq = s_reg.irq;
    for (genvar g = 0; g < NPORTS; g++) begin : g_out
        assign port_asleep[g] = (s_reg.sleep[g] == SPSF_ASLEEP);
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_plug_reads_one: assert property (
        (reg_rd && reg_addr == ADDR_SPEED && port_sel < PSEL_W'(NPORTS))
        |=> reg_rdata[SPD_PLUG_BIT] == 1'b1)
        else $error("local plug flag not read as one");

    a_strap_loads_enable: assert property (
        $rose(s_reg.strap_done) |-> s_reg.slpen == {NPORTS{$past(slpen_pin)}})
        else $error("sleep enables not loaded from strap");

    // a select beyond the last port must not leak another port's fields
    a_rdata_unsel: assert property (
        (reg_rd && port_sel >= PSEL_W'(NPORTS) && reg_addr <= ADDR_ERRCNT)
        |=> reg_rdata == '0)
        else $error("missing port returned data");

    // per-port checks
    for (genvar g = 0; g < NPORTS; g++) begin : g_chk
        sequence s_sel_rd(logic [3:0] a);
            reg_rd && reg_addr == a && port_sel == PSEL_W'(g);
        endsequence
        sequence s_sel_wr(logic [3:0] a);
            reg_wr && reg_addr == a && port_sel == PSEL_W'(g);
        endsequence

        a_limit_clamped: assert property (
            (s_sel_wr(ADDR_SPEED) and B_ONLY[g])
            |=> s_reg.limit[g] == spsf_clamp_speed($past(reg_wdata[2:0]), PORT_CAP[g]))
            else $error("speed limit write not clamped");
        a_bilingual_fixed: assert property (
            !B_ONLY[g] |-> s_reg.limit[g] == SPD_BILINGUAL)
            else $error("bilingual limit moved");
        a_train_source: assert property (
            new_b_conn[g] |=> train_speed[g] ==
                (B_ONLY[g] ? $past(s_reg.limit[g]) : SPD_BILINGUAL))
            else $error("training speed not taken from limit");
        a_cap_read: assert property (
            s_sel_rd(ADDR_SPEED) |=> reg_rdata[SPD_CAP_LSB +: 3] == PORT_CAP[g])
            else $error("capability field wrong");
        a_unrel_set: assert property (
            (neg_fail[g] || sync_fail[g]) |=> s_reg.unrel[g])
            else $error("failure did not set unreliable flag");
        a_unrel_clear: assert property (
            (s_sel_wr(ADDR_STATUS) and reg_wdata[ST_UNREL_BIT] && !neg_fail[g] && !sync_fail[g])
            |=> !s_reg.unrel[g])
            else $error("write one did not clear unreliable flag");
        a_bsig_needs_con: assert property (
            !port_connected[g] |-> !port_b_signaling[g])
            else $error("b indicator while disconnected");
        a_legacy_view: assert property (
            port_receive_good[g] |-> port_connected[g])
            else $error("receive good without connection");
        a_cnt_saturate: assert property (
            (s_reg.errcnt[g] == ERRCNT_MAX && invalid_code[g] && !reg_rd)
            |=> s_reg.errcnt[g] == ERRCNT_MAX)
            else $error("error counter wrapped");
        a_cnt_read_clear: assert property (
            (s_sel_rd(ADDR_ERRCNT) and !invalid_code[g])
            ##1 (!invalid_code[g]) |-> s_reg.errcnt[g] == ERRCNT_RST
                && reg_rdata == $past(s_reg.errcnt[g]))
            else $error("counter read did not clear");
        a_sleep_read: assert property (
            s_sel_rd(ADDR_STATUS) |=> reg_rdata[ST_SLEEP_BIT] == $past(port_asleep[g]))
            else $error("sleep flag read wrong");
        a_sleep_enabled: assert property (
            $rose(port_asleep[g]) |-> $past(s_reg.slpen[g]))
            else $error("sleep entered while disabled");
        a_other_port_kept: assert property (
            (reg_wr && port_sel != PSEL_W'(g)) |=> $stable(s_reg.limit[g]))
            else $error("write reached unselected port");
        // the training speed moves only when a new b connection is trained
        a_train_held: assert property (
            !new_b_conn[g] |=> $stable(train_speed[g]))
            else $error("training speed moved without a new connection");
        // the count steps up by one except at the ceiling or when a same-cycle read clears it first
        a_cnt_increment: assert property (
            (invalid_code[g] && s_reg.errcnt[g] != ERRCNT_MAX
                && !(reg_rd && reg_addr == ADDR_ERRCNT && port_sel == PSEL_W'(g)))
            |=> s_reg.errcnt[g] == $past(s_reg.errcnt[g]) + 8'h01)
            else $error("invalid code word not counted");
        // after the strap step the enable follows software writes
        a_slpen_write: assert property (
            (s_sel_wr(ADDR_STATUS) and s_reg.strap_done)
            |=> s_reg.slpen[g] == $past(reg_wdata[ST_SLPEN_BIT]))
            else $error("sleep enable write lost");
        // a wake request always leaves the sleep state
        a_wake_exit: assert property (
            (port_asleep[g] && wake_req[g]) |=> !port_asleep[g])
            else $error("port stayed asleep after wake request");
    end

endmodule

// ==== verif/spsf_tb.sv ====
// self-checking bench for the port status field bank
`timescale 1ns/100ps
module testbench;
    import spsf_pkg::*;
    localparam int NP = 3;
    localparam int DEB = 8;
    // port0 b-only S800, port1 b-only S200, port2 bilingual S400
    localparam logic [NP-1:0][2:0] CAP = {SPD_S400, SPD_S200, SPD_S800};
    localparam logic [NP-1:0] BONLY = 3'h3;
    logic clk_sys, arst_n, reg_wr, reg_rd, slpen_pin, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [PSEL_W-1:0] port_sel;
    logic [NP-1:0] phy_connect_raw, receive_good_in, b_link_up, new_b_conn;
    logic [NP-1:0] neg_fail, sync_fail, invalid_code, sleep_req, wake_req;
    logic [NP-1:0] port_connected, port_receive_good, port_b_signaling, port_asleep;
    logic [NP-1:0][2:0] train_speed;
    int err_count = 0;
    int checked = 0;

    spsf_port_status #(.NPORTS(NP), .PORT_CAP(CAP), .B_ONLY(BONLY),
        .DEBOUNCE_CYCLES(DEB)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port_sel(port_sel), .slpen_pin(slpen_pin),
        .phy_connect_raw(phy_connect_raw), .receive_good_in(receive_good_in),
        .b_link_up(b_link_up), .new_b_conn(new_b_conn), .neg_fail(neg_fail),
        .sync_fail(sync_fail), .invalid_code(invalid_code), .sleep_req(sleep_req),
        .wake_req(wake_req), .port_connected(port_connected),
        .port_receive_good(port_receive_good), .port_b_signaling(port_b_signaling),
        .port_asleep(port_asleep), .train_speed(train_speed), .irq(irq));

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, port select travels with it
    task automatic wr(input logic [1:0] p, input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        port_sel <= p;
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic rd(input logic [1:0] p, input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        port_sel <= p;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask

    function automatic logic [7:0] spd(input int p, input logic [2:0] lim);
        return {LOCAL_PLUG_VAL, CAP[p], 1'b0, lim};
    endfunction

    task automatic t_speed();
        logic [2:0] wv [5] = '{3'h5, 3'h7, 3'h1, 3'h0, 3'h0};
        logic [2:0] ev [5] = '{3'h3, 3'h3, 3'h1, 3'h0, 3'h2};
        int pv [5] = '{0, 0, 0, 1, 2};
        for (int p = 0; p < 4; p++) begin
            rd(p[1:0], ADDR_SPEED, d);
            if (p < NP) begin
                chk8(d, spd(p, BONLY[p] ? CAP[p] : SPD_BILINGUAL));
            end else begin
                chk8(d, 8'h00);
            end
        end
        for (int i = 0; i < 5; i++) begin
            wr(pv[i][1:0], ADDR_SPEED, {5'h0, wv[i]});
            rd(pv[i][1:0], ADDR_SPEED, d);
            chk8(d, spd(pv[i], ev[i]));
        end
        chk8({5'h0, train_speed[0]}, 8'h03);
        @(posedge clk_sys);
        new_b_conn <= 3'h7;
        @(posedge clk_sys);
        new_b_conn <= 3'h0;
        repeat (2) @(posedge clk_sys);
        chk8({5'h0, train_speed[0]}, 8'h01);
        chk8({5'h0, train_speed[1]}, 8'h00);
        chk8({5'h0, train_speed[2]}, {5'h0, SPD_BILINGUAL});
    endtask

    // failures set the flag, write-one clears it, interrupt follows the mask
    task automatic t_unrel();
        @(posedge clk_sys);
        neg_fail <= 3'h2;
        sync_fail <= 3'h1;
        @(posedge clk_sys);
        neg_fail <= 3'h0;
        sync_fail <= 3'h0;
        rd(2'h1, ADDR_STATUS, d);
        chk8(d, 8'h01);
        rd(2'h2, ADDR_STATUS, d);
        chk8(d, 8'h00);
        rd(2'h0, ADDR_IRQ_STAT, d);
        chk8(d, 8'h01);
        chk1(irq, 1'b0);
        wr(2'h0, ADDR_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk1(irq, 1'b1);
        wr(2'h1, ADDR_STATUS, 8'h01);
        rd(2'h1, ADDR_STATUS, d);
        chk8(d, 8'h00);
        rd(2'h0, ADDR_STATUS, d);
        chk8(d, 8'h01);
        wr(2'h0, ADDR_IRQ_STAT, 8'h0f);
        repeat (2) @(posedge clk_sys);
        chk1(irq, 1'b0);
        rd(2'h0, 4'hf, d);
        chk8(d, 8'h00);
    endtask

    // a long burst must stop at the ceiling rather than wrap
    task automatic t_errcnt();
        @(posedge clk_sys);
        invalid_code <= 3'h1;
        repeat (260) @(posedge clk_sys);
        invalid_code <= 3'h2;
        repeat (3) @(posedge clk_sys);
        invalid_code <= 3'h0;
        rd(2'h0, ADDR_ERRCNT, d);
        chk8(d, ERRCNT_MAX);
        rd(2'h0, ADDR_ERRCNT, d);
        chk8(d, 8'h00);
        rd(2'h1, ADDR_ERRCNT, d);
        chk8(d, 8'h03);
    endtask

    task automatic t_sleep();
        rd(2'h0, ADDR_STATUS, d);
        chk8(d, 8'h01);
        @(posedge clk_sys);
        sleep_req <= 3'h1;
        @(posedge clk_sys);
        sleep_req <= 3'h0;
        repeat (2) @(posedge clk_sys);
        chk1(port_asleep[0], 1'b0);
        wr(2'h0, ADDR_STATUS, 8'h20);
        @(posedge clk_sys);
        sleep_req <= 3'h1;
        @(posedge clk_sys);
        sleep_req <= 3'h0;
        repeat (2) @(posedge clk_sys);
        chk1(port_asleep[0], 1'b1);
        rd(2'h0, ADDR_STATUS, d);
        chk8(d, 8'h31);
        @(posedge clk_sys);
        wake_req <= 3'h1;
        @(posedge clk_sys);
        wake_req <= 3'h0;
        repeat (2) @(posedge clk_sys);
        chk1(port_asleep[0], 1'b0);
    endtask

    // connection must stay low through the whole debounce, then rise one flop later
    task automatic t_connect();
        @(posedge clk_sys);
        phy_connect_raw <= 3'h1;
        receive_good_in <= 3'h1;
        repeat (DEB) @(posedge clk_sys);
        @(negedge clk_sys);
        chk1(port_connected[0], 1'b0);
        @(negedge clk_sys);
        chk1(port_connected[0], 1'b1);
        chk1(port_receive_good[0], 1'b1);
        chk1(port_b_signaling[0], 1'b0);
        @(posedge clk_sys);
        b_link_up <= 3'h1;
        repeat (3) @(posedge clk_sys);
        chk1(port_b_signaling[0], 1'b1);
        rd(2'h0, ADDR_STATUS, d);
        chk8(d, 8'h2f);
        @(posedge clk_sys);
        phy_connect_raw <= 3'h0;
        repeat (4) @(posedge clk_sys);
        chk1(port_b_signaling[0], 1'b0);
        chk1(port_receive_good[0], 1'b0);
        b_link_up <= 3'h0;
        receive_good_in <= 3'h0;
        // code, connection change and sleep events all left their marks
        rd(2'h0, ADDR_IRQ_STAT, d);
        chk8(d, 8'h0e);
    endtask

    // a second reset with the strap high: enables load, limits return to capability
    task automatic t_strap();
        @(posedge clk_sys);
        slpen_pin <= 1'b1;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        slpen_pin <= 1'b0;
        rd(2'h1, ADDR_STATUS, d);
        chk8(d, 8'h20);
        rd(2'h0, ADDR_SPEED, d);
        chk8(d, spd(0, CAP[0]));
    endtask

    task automatic test_done();
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // all inputs quiet, reset held for 20 cycles
    initial begin
        arst_n = 1'b0;
        {reg_wr, reg_rd, slpen_pin, reg_addr, reg_wdata, port_sel} = '0;
        {phy_connect_raw, receive_good_in, b_link_up, new_b_conn} = '0;
        {neg_fail, sync_fail, invalid_code, sleep_req, wake_req} = '0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_speed();
        t_unrel();
        t_errcnt();
        t_sleep();
        t_connect();
        t_strap();
        test_done();
    end

    // the tests need well under 1000 cycles; give generous slack
    initial begin
        #2_000_000;
        err_count++;
        test_done();
    end
endmodule
